// *** hw/ivc_defs.svh ***
// Constants for the regulator control register block
`ifndef IVC_DEFS_SVH
`define IVC_DEFS_SVH
`define IVC_REG_LEVEL     1'h0
`define IVC_REG_CTRL      1'h1
`define IVC_CODE_RST      7'h32
`define IVC_PAR_RST       1'h0
`define IVC_CTL_RST       8'h09
`define IVC_CTL_INT_BIT   7
`define IVC_CTL_MASK_BIT  4
`define IVC_CTL_PWM_BIT   3
`define IVC_CTL_LATCH_BIT 0
`define IVC_BYTE_BITS     4'h8
`define IVC_SPIKE_NS      32
`define IVC_CLK_NS        5
`define IVC_FILT_CYC      ((`IVC_SPIKE_NS / `IVC_CLK_NS) + 2)
`endif

// *** hw/ivc_pkg.sv ***
// Types shared by the regulator control register block
`include "ivc_defs.svh"
package ivc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR  = 3'b010,
        ST_WDAT = 3'b011,
        ST_ACK  = 3'b100,
        ST_RDAT = 3'b101,
        ST_SKIP = 3'b110
    } ivc_state_t;

    typedef struct packed {
        logic [1:0]      s1;
        logic [1:0]      s2;
        logic [1:0]      f;
        logic [1:0][3:0] cnt;
    } ivc_filt_t;

    typedef struct packed {
        ivc_state_t st;
        ivc_state_t after;
        logic       scl_p;
        logic       sda_p;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic       ptr;
        logic       pin_s1;
        logic       pin_s2;
        logic [6:0] code;
        logic       par;
        logic       ctl_int;
        logic       ctl_mask;
        logic       ctl_pwm;
        logic       ctl_latch;
        logic       sda_oe;
        logic       sda_lvl;
        logic       upd;
        logic       hold;
    } ivc_regs_t;

    // Parity bit must equal the XNOR of the seven low bits
    function automatic logic ivc_par_ok(input logic [7:0] b);
        return b[7] == ~(^b[6:0]);
    endfunction
endpackage

// *** hw/ivc_line_if.sv ***
// Filtered bus lines passed from the input filter to the protocol logic
interface ivc_line_if;
    logic scl;
    logic sda;
    modport src (output scl, output sda);
    modport dst (input scl, input sda);
endinterface

// *** hw/ivc_glitch_filter.sv ***
// Synchroniser and spike filter for the two bus lines
`include "ivc_defs.svh"
module ivc_glitch_filter #(
    parameter int FILT_CYC = `IVC_FILT_CYC
) (
    input  wire logic   mclk_i,
    input  wire logic   srst_i,
    input  wire logic   scl_i,
    input  wire logic   sda_i,
    ivc_line_if.src     line
);
    import ivc_pkg::*;

    ivc_filt_t q;
    ivc_filt_t d;

    if (FILT_CYC < 2 || FILT_CYC > 15) begin : g_chk
        $error("FILT_CYC out of range");
    end

    always_comb begin
        d = q;
        d.s1 = {scl_i, sda_i};
        d.s2 = q.s1;
        // A change must persist longer than the widest spike before it passes
        for (int i = 0; i < 2; i++) begin
            if (q.s2[i] == q.f[i]) begin
                d.cnt[i] = 4'h0;
            end else if (q.cnt[i] == 4'(FILT_CYC - 1)) begin
                d.f[i] = q.s2[i]; // see (R12)
                d.cnt[i] = 4'h0;
            end else begin
                d.cnt[i] = q.cnt[i] + 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            q <= '{s1: 2'h3, s2: 2'h3, f: 2'h3, cnt: '0};
        end else begin
            q <= d;
        end
    end

    assign line.scl = q.f[1];
    assign line.sda = q.f[0];

    spike_block_a: assert property (@(posedge mclk_i) disable iff (srst_i) // see (R12)
        $changed(q.f[0]) |-> ($past(q.s2[0], 1) == q.f[0]
                              && $past(q.s2[0], 7) == q.f[0]))
        else $error("filtered line changed without a stable input");
endmodule

// *** hw/ivc_regs.sv ***
// Two-wire slave holding the output level setpoint and control register
`include "ivc_defs.svh"
// Contract
// (R1) Level register at 00: code 6:0, parity 7
// (R2) Code resets to 0110010
// (R3) Control bit 7 selects internal setpoint
// (R4) Writing 0 there returns to external control
// (R5) Control bit 4 suspends protection on change
// (R6) Control bit 3 picks PWM, default 1
// (R7) Control bit 0 picks latch-off, default 1
// (R8) Master sends parity as XNOR of code
// (R9) Bad parity: no acknowledge, nothing stored
// (R10) Master retries an unacknowledged write
// (R11) Level read returns stored parity bit
// (R12) Spikes up to 32 ns are ignored
// (R13) Matching address acknowledged on ninth pulse
// (R14) Mismatch: no acknowledge, wait for START
// (R15) Bit after address gives the direction
// (R16) Read shifts eight bits, then awaits STOP
// (R17) Write carries register pointer then data
// (R18) Unused control bits read zero
module ivc_regs #(
    parameter logic [5:0] DEV_ADDR_HI = 6'h15, // Arbitrary bus address
    parameter int         FILT_CYC    = `IVC_FILT_CYC
) (
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       address_select_pin_i,
    output logic [6:0]      output_level_code_o,
    output logic            internal_mode_o,
    output logic            protect_mask_on_change_o,
    output logic            light_load_pwm_select_o,
    output logic            latch_off_mode_o,
    output logic            setpoint_update_o,
    output logic            protect_hold_o
);
    import ivc_pkg::*;

    // Reset word as a vector, so single bits can be picked from it
    localparam logic [7:0] CTL_RST = `IVC_CTL_RST;

    ivc_regs_t q;
    ivc_regs_t d;
    ivc_line_if line ();

    ivc_glitch_filter #(.FILT_CYC(FILT_CYC)) u_filt (
        .mclk_i (mclk_i),
        .srst_i (srst_i),
        .scl_i  (scl_i),
        .sda_i  (sda_i),
        .line   (line)
    );

    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       addr_hit;
    logic [7:0] rd_word;

    assign scl_rise = line.scl & ~q.scl_p;
    assign scl_fall = ~line.scl & q.scl_p;
    assign start_c  = line.scl & q.scl_p & q.sda_p & ~line.sda;
    assign stop_c   = line.scl & q.scl_p & ~q.sda_p & line.sda;
    assign addr_hit = q.sh[7:1] == {DEV_ADDR_HI, q.pin_s2}; // see (R13)

    always_comb begin
        if (q.ptr == `IVC_REG_LEVEL) begin
            rd_word = {q.par, q.code}; // see (R11)
        end else begin
            rd_word = {q.ctl_int, 2'h0, q.ctl_mask, q.ctl_pwm, 2'h0,
                       q.ctl_latch}; // see (R18)
        end
    end

    always_comb begin
        d = q;
        d.upd = 1'b0;
        d.hold = 1'b0;
        d.scl_p = line.scl;
        d.sda_p = line.sda;
        d.pin_s1 = address_select_pin_i;
        d.pin_s2 = q.pin_s1;
        if (start_c) begin
            d.st = ST_ADDR;
            d.cnt = 4'h0;
            d.sda_oe = 1'b0;
        end else if (stop_c) begin
            d.st = ST_IDLE;
            d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            if (q.st == ST_ADDR || q.st == ST_PTR || q.st == ST_WDAT) begin
                d.sh = {q.sh[6:0], line.sda};
                d.cnt = q.cnt + 4'h1;
            end else if (q.st == ST_RDAT) begin
                d.cnt = q.cnt + 4'h1;
            end
        end else if (scl_fall) begin
            case (q.st)
                ST_ADDR: begin
                    if (q.cnt == `IVC_BYTE_BITS) begin
                        if (addr_hit) begin
                            d.sda_oe = 1'b1; // see (R13)
                            d.st = ST_ACK;
                            // Direction bit picks read or pointer phase
                            d.after = q.sh[0] ? ST_RDAT : ST_PTR; // see (R15)
                        end else begin
                            d.st = ST_SKIP; // see (R14)
                        end
                    end
                end
                ST_PTR: begin
                    if (q.cnt == `IVC_BYTE_BITS) begin
                        if (q.sh[7:1] == 7'h00) begin
                            d.ptr = q.sh[0]; // see (R17)
                            d.sda_oe = 1'b1;
                            d.st = ST_ACK;
                            d.after = ST_WDAT;
                        end else begin
                            d.st = ST_SKIP;
                        end
                    end
                end
                ST_WDAT: begin
                    if (q.cnt == `IVC_BYTE_BITS) begin
                        // Corrupted bytes are dropped so the master retries
                        if (ivc_par_ok(q.sh)) begin // see (R9)
                            d.sda_oe = 1'b1;
                            d.st = ST_ACK;
                            d.after = ST_SKIP;
                            if (q.ptr == `IVC_REG_LEVEL) begin
                                d.code = q.sh[6:0]; // see (R1)
                                d.par = q.sh[7];
                                d.upd = 1'b1;
                                d.hold = q.ctl_mask; // see (R5)
                            end else begin
                                d.ctl_int = q.sh[`IVC_CTL_INT_BIT]; // see (R3) (R4)
                                d.ctl_mask = q.sh[`IVC_CTL_MASK_BIT];
                                d.ctl_pwm = q.sh[`IVC_CTL_PWM_BIT]; // see (R6)
                                d.ctl_latch = q.sh[`IVC_CTL_LATCH_BIT]; // see (R7)
                            end
                        end else begin
                            d.st = ST_SKIP;
                        end
                    end
                end
                ST_ACK: begin
                    d.cnt = 4'h0;
                    d.st = q.after;
                    if (q.after == ST_RDAT) begin
                        d.sh = rd_word;
                        d.sda_oe = ~rd_word[7];
                    end else begin
                        d.sda_oe = 1'b0;
                    end
                end
                ST_RDAT: begin
                    // Master acknowledge is not checked; only a STOP or a repeated START ends it
                    if (q.cnt == `IVC_BYTE_BITS) begin
                        d.sda_oe = 1'b0;
                        d.st = ST_SKIP; // see (R16)
                    end else begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oe = ~q.sh[6];
                    end
                end
                default: begin
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            q <= '{st: ST_IDLE, after: ST_IDLE, scl_p: 1'b1, sda_p: 1'b1,
                   cnt: 4'h0, sh: 8'h00, ptr: `IVC_REG_LEVEL,
                   pin_s1: 1'b0, pin_s2: 1'b0,
                   code: `IVC_CODE_RST, par: `IVC_PAR_RST, // see (R2)
                   ctl_int: CTL_RST[`IVC_CTL_INT_BIT],
                   ctl_mask: CTL_RST[`IVC_CTL_MASK_BIT],
                   ctl_pwm: CTL_RST[`IVC_CTL_PWM_BIT],
                   ctl_latch: CTL_RST[`IVC_CTL_LATCH_BIT],
                   sda_oe: 1'b0, sda_lvl: 1'b0, upd: 1'b0, hold: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign sda_o                    = q.sda_lvl;
    assign sda_oe_o                 = q.sda_oe;
    assign output_level_code_o      = q.code;
    assign internal_mode_o          = q.ctl_int;
    assign protect_mask_on_change_o = q.ctl_mask;
    assign light_load_pwm_select_o  = q.ctl_pwm;
    assign latch_off_mode_o         = q.ctl_latch;
    assign setpoint_update_o        = q.upd;
    assign protect_hold_o           = q.hold;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    logic byte_end;
    assign byte_end = scl_fall && !start_c && !stop_c
                      && q.cnt == `IVC_BYTE_BITS;

    reset_values_a: assert property ($fell(srst_i) |-> // see (R2)
        output_level_code_o == 7'h32 && !internal_mode_o
        && light_load_pwm_select_o && latch_off_mode_o)
        else $error("wrong values after reset");
    addr_ack_a: assert property ( // see (R13)
        q.st == ST_ADDR && byte_end && addr_hit
        |=> sda_oe_o && q.st == ST_ACK)
        else $error("matching address not acknowledged");
    addr_miss_a: assert property ( // see (R14)
        q.st == ST_ADDR && byte_end && !addr_hit
        |=> !sda_oe_o && q.st == ST_SKIP)
        else $error("foreign address acknowledged");
    parity_drop_a: assert property ( // see (R9)
        q.st == ST_WDAT && byte_end && !ivc_par_ok(q.sh)
        |=> !sda_oe_o && $stable(output_level_code_o)
            && $stable(internal_mode_o) && !setpoint_update_o)
        else $error("bad parity byte accepted");
    level_write_a: assert property ( // see (R1)
        q.st == ST_WDAT && byte_end && ivc_par_ok(q.sh) && !q.ptr
        |=> output_level_code_o == $past(q.sh[6:0]) && setpoint_update_o
            ##1 !setpoint_update_o)
        else $error("level write not stored");
    ext_return_a: assert property ( // see (R4)
        q.st == ST_WDAT && byte_end && ivc_par_ok(q.sh) && q.ptr
        && !q.sh[7] |=> !internal_mode_o)
        else $error("internal mode not cleared");
    ctl_write_a: assert property ( // see (R6) (R7)
        q.st == ST_WDAT && byte_end && ivc_par_ok(q.sh) && q.ptr
        |=> light_load_pwm_select_o == $past(q.sh[3])
            && latch_off_mode_o == $past(q.sh[0]))
        else $error("control write not stored");
    read_load_a: assert property ( // see (R11)
        q.st == ST_ACK && q.after == ST_RDAT && scl_fall && !start_c
        && !stop_c && !q.ptr |=> q.sh == {q.par, q.code}
        && sda_oe_o == !q.par)
        else $error("level read word wrong");
    hold_pulse_a: assert property ( // see (R5)
        protect_hold_o |-> setpoint_update_o && protect_mask_on_change_o)
        else $error("protection hold without masked update");
endmodule

// *** verif/ivc_master.sv ***
// Two-wire bus master model that drives the register block
module ivc_master #(
    parameter int Q = 12
) (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic glitch = 1'b0;

    // Bus idles high; SCL stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // One bit, SCL low on entry
    task automatic bit_io(input logic b, output logic r);
        tick(Q);
        sda_o <= b;
        tick(Q);
        scl_o <= 1'b1;
        if (glitch) begin
            // 25 ns spike, inside the filter width
            tick(2);
            sda_o <= ~b;
            tick(5);
            sda_o <= b;
            tick(Q - 7);
        end else begin
            tick(Q);
        end
        r = sda_i;
        tick(Q);
        scl_o <= 1'b0;
    endtask

    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Master answer left high; the block must not care
    task automatic rx(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
    endtask

    // Address, then pointer and data, or one byte back
    task automatic xfer(input logic [7:0] a, input logic [7:0] p,
                        input logic [7:0] d, input int n,
                        output logic [2:0] ak, output logic [7:0] rd);
        logic k;
        ak = 3'b000;
        rd = 8'h00;
        tick(1);
        sda_o <= 1'b0;
        tick(Q);
        scl_o <= 1'b0;
        tx(a, k);
        ak[0] = k;
        if (a[0]) begin
            rx(rd);
        end else begin
            if (n > 1) tx(p, k);
            if (n > 1) ak[1] = k;
            if (n > 2) tx(d, k);
            if (n > 2) ak[2] = k;
        end
        tick(Q);
        sda_o <= 1'b0;
        tick(Q);
        scl_o <= 1'b1;
        tick(Q);
        sda_o <= 1'b1;
        tick(4 * Q);
    endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the regulator control register block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] DEV = {6'h15, 1'b1, 1'b0};

    logic       mclk_i = 1'b0;
    logic       srst_i = 1'b1;
    logic       pin    = 1'b1;
    logic       scl, sda_m, sda_oe, sda_d, upd, hold;
    logic [6:0] code;
    logic [3:0] mode;
    logic [7:0] m_lvl = 8'h32;
    logic [7:0] m_ctl = 8'h09;
    logic [7:0] rnd   = 8'h02;
    logic [7:0] dv;
    logic [2:0] ak;
    int         fail_count = 0;
    int         samples_checked = 0;
    int         n_upd = 0, n_hold = 0, e_upd = 0, e_hold = 0;
    // Open drain with pull-up: low wins
    wire        sda_w = sda_m & (sda_oe ? sda_d : 1'b1);

    always #2.5 mclk_i = ~mclk_i;

    ivc_regs dut_u (
        .mclk_i                   (mclk_i),
        .srst_i                   (srst_i),
        .scl_i                    (scl),
        .sda_i                    (sda_w),
        .sda_o                    (sda_d),
        .sda_oe_o                 (sda_oe),
        .address_select_pin_i     (pin),
        .output_level_code_o      (code),
        .internal_mode_o          (mode[3]),
        .protect_mask_on_change_o (mode[2]),
        .light_load_pwm_select_o  (mode[1]),
        .latch_off_mode_o         (mode[0]),
        .setpoint_update_o        (upd),
        .protect_hold_o           (hold)
    );

    ivc_master mst_u (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl),
                      .sda_o(sda_m));

    always @(posedge mclk_i) begin
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (hold === 1'b1) n_hold <= n_hold + 1;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic chk_ack(input logic [2:0] got, input logic [2:0] exp);
        chk_val({5'h00, got}, {5'h00, exp});
    endtask

    task automatic chk_outs();
        logic [7:0] c;
        c = {mode[3], 2'b00, mode[2:1], 2'b00, mode[0]};
        chk_val({1'b0, code}, {1'b0, m_lvl[6:0]});
        chk_val(c, m_ctl);
        chk_val(8'(n_upd), 8'(e_upd));
        chk_val(8'(n_hold), 8'(e_hold));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] p,
                      input logic [7:0] d);
        logic [7:0] r;
        logic [2:0] e;
        e[0] = (a == {DEV[7:2], pin, 1'b0});
        e[1] = e[0] && (p < 8'h02);
        e[2] = e[1] && (d[7] == ~^d[6:0]);
        mst_u.xfer(a, p, d, 3, ak, r);
        chk_ack(ak, e);
        if (e[2] && p == 8'h00) begin
            m_lvl = d;
            e_upd++;
            if (m_ctl[4]) e_hold++;
        end else if (e[2]) begin
            m_ctl = d & 8'h99;
        end
        chk_outs();
    endtask

    task automatic rd(input logic [7:0] p);
        logic [7:0] r;
        mst_u.xfer(DEV, p, 8'h00, 2, ak, r);
        chk_ack(ak, 3'b011);
        mst_u.xfer(DEV | 8'h01, 8'h00, 8'h00, 1, ak, r);
        chk_ack(ak, 3'b001);
        chk_val(r, p[0] ? m_ctl : m_lvl);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (30) @(posedge mclk_i);
        chk_outs();
        rd(8'h00);
        rd(8'h01);
        wr(8'h20, 8'h00, 8'h80);
        wr(DEV, 8'h02, 8'h80);
        wr(DEV, 8'h01, 8'h98);
        for (int i = 0; i < 4; i++) begin
            mst_u.glitch = i[0];
            // Parity is the XNOR of the code bits
            rnd = lfsr(rnd);
            dv = {~^rnd[6:0], rnd[6:0]};
            wr(DEV, 8'h00, dv ^ 8'h80);
            wr(DEV, 8'h00, dv);
            rnd = lfsr(rnd);
            dv = {~^rnd[6:0], rnd[6:0]};
            wr(DEV, 8'h01, dv ^ 8'h80);
            wr(DEV, 8'h01, dv);
            rd(8'h00);
            rd(8'h01);
        end
        mst_u.glitch = 1'b0;
        wr(DEV, 8'h01, 8'h80);
        wr(DEV, 8'h01, 8'h01);
        // A reset in mid-run must bring back the power-up values
        srst_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (30) @(posedge mclk_i);
        m_lvl = 8'h32;
        m_ctl = 8'h09;
        chk_outs();
        rd(8'h00);
        // Strap low moves the bus address; the old one is foreign now
        pin <= 1'b0;
        repeat (30) @(posedge mclk_i);
        rnd = lfsr(rnd);
        dv = {~^rnd[6:0], rnd[6:0]};
        wr({DEV[7:2], 2'b00}, 8'h00, dv);
        wr(DEV, 8'h00, dv ^ 8'h81);
        close_out();
    end

    // Full run is near 53300 cycles
    initial begin
        repeat (80000) @(posedge mclk_i);
        fail_count++;
        close_out();
    end
endmodule
